// ---- spc_top.v ----
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Control bits 7 and 6 select the signal type on port A.
// - Type 00 is field vertical sync, 01 odd/even frame sync, 10 colour sequence, 11 unused.
// - Colour sequence mode gives vsync every 4th (NTSC), 8th (PAL) or 12th (SECAM) field.
// - Bit 5 picks hsync from port A or embedded code when clear, from port B when set.
// - Bit 4 makes port A an output when set, an input when clear.
// - Bit 3 sets port A polarity: active low output and falling input edge when set.
// - With bit 2 clear and port B output, port B drives the line reference pulse.
// - With bit 2 clear, port B input and no embedded sync, port B feeds hsync only.
// - With bit 2 set and port B output, port B drives blanking pulse outside vblank.
// - With bit 2 set, port B input and no embedded sync, port B is hsync and blanking.
// - Bit 1 makes port B an output when set, an input when clear.
// - Bit 0 sets port B polarity: active low output and falling input edge when set.
// - Reset clears every control bit.
`include "spc_map.vh"
module spc_top #(
  parameter LINE_W = 11,
  parameter PIX_W  = 11
) (
  // Clock and reset
  input  wire              clock,
  input  wire              rstn,
  // APB slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  // Internal timing from the encoder
  input  wire [PIX_W-1:0]  pixel_count,
  input  wire [LINE_W-1:0] line_count,
  input  wire              field_start,
  input  wire              odd_field,
  input  wire              embedded_hsync,
  // Sync port A
  input  wire              sync_port_a_i,
  output reg               sync_port_a_o,
  output reg               sync_port_a_oe,
  // Sync port B
  input  wire              sync_port_b_i,
  output reg               sync_port_b_o,
  output reg               sync_port_b_oe,
  // Decoded results
  output reg               hsync_event,
  output reg               vsync_event,
  output reg               ext_blank
);
  ////////////////////////////////////////////////////////////////////////////
  reg  [7:0]        control;
  reg               embedded_sync_select;
  reg  [1:0]        video_std;
  reg  [PIX_W-1:0]  port_b_pulse_start;
  reg  [PIX_W-1:0]  port_b_pulse_end;
  reg  [LINE_W-1:0] first_active_line;
  reg  [LINE_W-1:0] last_active_line;
  reg  [3:0]        field_index;
  reg               pb_active;
  reg               pa_active;
  wire              port_a_type_hi        = control[`SPC_TYPE_HI_BIT];
  wire              port_a_type_lo        = control[`SPC_TYPE_LO_BIT];
  wire [1:0]        port_a_type           = {port_a_type_hi, port_a_type_lo};
  wire              hsync_source_sel      = control[`SPC_HSRC_BIT];
  wire              port_a_direction      = control[`SPC_A_DIR_BIT];
  wire              port_a_polarity       = control[`SPC_A_POL_BIT];
  wire              port_b_blank_function = control[`SPC_B_BLANK_BIT];
  wire              port_b_direction      = control[`SPC_B_DIR_BIT];
  wire              port_b_polarity       = control[`SPC_B_POL_BIT];
  wire              a_level;
  wire              a_edge;
  wire              b_level;
  wire              b_edge;
  wire              wr_en = psel & penable & pwrite & ~pready;
  wire              rd_en = psel & ~penable;
  wire [3:0]        seq_last;
  wire              seq_hit;
  wire              in_line;
  wire              in_vblank;
  wire              a_listens             = ~port_a_direction;
  wire              b_listens             = ~port_b_direction & ~embedded_sync_select;
  reg               next_hsync_event;

  function addr_ok;
    input [11:0] a;
    begin
      addr_ok = (a == `SPC_ADDR_CONTROL) | (a == `SPC_ADDR_STATUS) |
                (a == `SPC_ADDR_MODE) | (a == `SPC_ADDR_TIMING);
    end
  endfunction

  // Last field index of one colour sequence, per standard
  function [3:0] seq_length;
    input [1:0] std;
    begin
      case (std)
        `SPC_STD_PAL: begin
          seq_length = `SPC_SEQ_PAL;
        end
        `SPC_STD_SECAM: begin
          seq_length = `SPC_SEQ_SECAM;
        end
        default: begin
          seq_length = `SPC_SEQ_NTSC;
        end
      endcase
    end
  endfunction

  // Pin level of a port: active pulse flipped for active-low polarity
  function drive_level;
    input active;
    input active_low;
    begin
      drive_level = active ^ active_low;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  spc_edge u_edge_a (
    .clock      (clock),
    .rstn       (rstn),
    .pin_in     (sync_port_a_i),
    .falling    (port_a_polarity),
    .level      (a_level),
    .edge_pulse (a_edge)
  );

  spc_edge u_edge_b (
    .clock      (clock),
    .rstn       (rstn),
    .pin_in     (sync_port_b_i),
    .falling    (port_b_polarity),
    .level      (b_level),
    .edge_pulse (b_edge)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB: one wait state, access phase answers on its second cycle
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      control              <= `SPC_CONTROL_RESET;
      embedded_sync_select <= 1'b0;
      video_std            <= `SPC_STD_NTSC;
      port_b_pulse_start   <= {PIX_W{1'b0}};
      port_b_pulse_end     <= {PIX_W{1'b0}};
      first_active_line    <= {LINE_W{1'b0}};
      last_active_line     <= {LINE_W{1'b0}};
      prdata               <= 32'h0000_0000;
      pready               <= 1'b0;
      pslverr              <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok(paddr);
      if (wr_en) begin
        case (paddr)
          `SPC_ADDR_CONTROL: begin
            control <= pwdata[7:0];
          end
          `SPC_ADDR_MODE: begin
            embedded_sync_select <= pwdata[0];
            video_std            <= pwdata[5:4];
          end
          `SPC_ADDR_TIMING: begin
            port_b_pulse_start <= pwdata[PIX_W-1:0];
            port_b_pulse_end   <= pwdata[16+PIX_W-1:16];
          end
          `SPC_ADDR_STATUS: begin
            first_active_line <= pwdata[LINE_W-1:0];
            last_active_line  <= pwdata[16+LINE_W-1:16];
          end
          default: begin
            control <= control;
          end
        endcase
      end
      if (rd_en) begin
        case (paddr)
          `SPC_ADDR_CONTROL: begin
            prdata <= {24'h00_0000, control};
          end
          `SPC_ADDR_MODE: begin
            prdata <= {26'h000_0000, video_std, 3'b000, embedded_sync_select};
          end
          `SPC_ADDR_TIMING: begin
            prdata <= {{(16-PIX_W){1'b0}}, port_b_pulse_end,
                       {(16-PIX_W){1'b0}}, port_b_pulse_start};
          end
          `SPC_ADDR_STATUS: begin
            prdata <= {{(16-LINE_W){1'b0}}, last_active_line,
                       {(16-LINE_W){1'b0}}, first_active_line};
          end
          default: begin
            prdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Colour sequence field counter
  // Sequence length follows the standard held in the mode register
  assign seq_last = seq_length(video_std);
  assign seq_hit  = (field_index == 4'h0);

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      field_index <= 4'h0;
    end else if (field_start) begin
      field_index <= (field_index >= seq_last) ? 4'h0 : field_index + 4'h1;
    end
  end

  // Line window for port B; pulse_end exclusive
  assign in_line   = (pixel_count >= port_b_pulse_start) && (pixel_count < port_b_pulse_end);
  // Vertical blanking outside first..last active line
  assign in_vblank = (line_count < first_active_line) || (line_count > last_active_line);

  ////////////////////////////////////////////////////////////////////////////
  // Port A output pulse: one clock at field start, gated by type
  always @* begin
    case (port_a_type)
      `SPC_TYPE_VS:   pa_active = field_start;
      `SPC_TYPE_FS:   pa_active = field_start & odd_field;
      `SPC_TYPE_COLOUR_SEQUENCE_SYNC: pa_active = field_start & seq_hit;
      default:        pa_active = 1'b0;
    endcase
  end

  always @* begin
    if (port_b_blank_function) begin
      pb_active = in_line & ~in_vblank;
    end else begin
      pb_active = in_line;
    end
  end

  // Hsync source: port A or embedded code with bit 5 clear, port B with it set
  always @* begin
    case ({hsync_source_sel, embedded_sync_select})
      2'b00: begin
        next_hsync_event = a_listens & a_edge;
      end
      2'b01: begin
        next_hsync_event = embedded_hsync;
      end
      2'b10: begin
        next_hsync_event = b_listens & b_edge;
      end
      default: begin
        // Port B is never a source while embedded sync is on
        next_hsync_event = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port A pins; enable and level registered together so they never skew
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync_port_a_o  <= 1'b0;
      sync_port_a_oe <= 1'b0;
    end else begin
      sync_port_a_oe <= port_a_direction;
      sync_port_a_o  <= drive_level(pa_active, port_a_polarity);
    end
  end

  // Port B pins
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync_port_b_o  <= 1'b0;
      sync_port_b_oe <= 1'b0;
    end else begin
      sync_port_b_oe <= port_b_direction;
      sync_port_b_o  <= drive_level(pb_active, port_b_polarity);
    end
  end

  // Events only from a port that listens; a driving port would echo itself
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hsync_event <= 1'b0;
      vsync_event <= 1'b0;
    end else begin
      hsync_event <= next_hsync_event;
      // Vertical sync from port A only
      vsync_event <= a_listens & a_edge;
    end
  end

  // Blanking follows port B level only in blank-function input mode
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ext_blank <= 1'b0;
    end else begin
      ext_blank <= port_b_blank_function & b_listens & b_level;
    end
  end
endmodule
`default_nettype wire

// ---- spc_map.vh ----
`ifndef SPC_MAP_VH
`define SPC_MAP_VH
// Control sits at word index 0x6b; its byte address is four times that
`define SPC_IDX_CONTROL       8'h6b
`define SPC_ADDR_CONTROL      12'h1ac
`define SPC_ADDR_STATUS       12'h070
`define SPC_ADDR_MODE         12'h074
`define SPC_ADDR_TIMING       12'h078
`define SPC_CONTROL_RESET     8'h00
`define SPC_TYPE_HI_BIT       7
`define SPC_TYPE_LO_BIT       6
`define SPC_HSRC_BIT          5
`define SPC_A_DIR_BIT         4
`define SPC_A_POL_BIT         3
`define SPC_B_BLANK_BIT       2
`define SPC_B_DIR_BIT         1
`define SPC_B_POL_BIT         0
`define SPC_TYPE_VS           2'b00
`define SPC_TYPE_FS           2'b01
`define SPC_TYPE_COLOUR_SEQUENCE_SYNC         2'b10
`define SPC_STD_NTSC          2'b00
`define SPC_STD_PAL           2'b01
`define SPC_STD_SECAM         2'b10
`define SPC_SEQ_NTSC          4'h3
`define SPC_SEQ_PAL           4'h7
`define SPC_SEQ_SECAM         4'hb
`endif

// ---- spc_edge.v ----
`timescale 1ns/100ps
`default_nettype none
// Two-flop synchroniser, then edge pick by polarity
module spc_edge (
  // Clock and reset
  input  wire clock,
  input  wire rstn,
  // Pin side
  input  wire pin_in,
  input  wire falling,
  // Result
  output reg  level,
  output reg  edge_pulse
);
  reg       meta;
  reg       sync;
  reg       last;
  reg [2:0] fill;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta       <= 1'b0;
      sync       <= 1'b0;
      last       <= 1'b0;
      fill       <= 3'b000;
      level      <= 1'b0;
      edge_pulse <= 1'b0;
    end else begin
      meta       <= pin_in;
      sync       <= meta;
      last       <= sync;
      // No events until the flops hold real pin values, so no false edge after reset
      fill       <= {fill[1:0], 1'b1};
      // Level normalised to active high
      level      <= sync ^ falling;
      // Raw edge picked by polarity, so a polarity write alone makes no event
      edge_pulse <= fill[2] & (falling ? (last & ~sync) : (sync & ~last));
    end
  end
endmodule
`default_nettype wire

// ---- spc_top_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module spc_top_checker (
  // Watched top ports
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sync_port_a_oe,
  input wire logic        sync_port_b_oe,
  input wire logic        hsync_event,
  input wire logic        vsync_event
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  wire acc = psel && penable && !pready;
  wire cw = acc && pwrite && paddr == 12'h1ac;
  wire unm = acc && !(paddr inside {12'h1ac, 12'h070, 12'h074, 12'h078});
  property p_rdy; pready |=> !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready long");
  property p_unm; unm |=> pready && pslverr; endproperty
  a_unm: assert property (p_unm) else $error("no pslverr");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("stray pslverr");
  property p_adir; $changed(sync_port_a_oe) |-> $past(cw) || $past(cw, 2); endproperty
  a_adir: assert property (p_adir) else $error("a enable moved");
  property p_bdir; $changed(sync_port_b_oe) |-> $past(cw) || $past(cw, 2); endproperty
  a_bdir: assert property (p_bdir) else $error("b enable moved");
  property p_rst; $rose(rstn) |-> !sync_port_a_oe && !sync_port_b_oe; endproperty
  a_rst: assert property (p_rst) else $error("pins driven");
  property p_hev; hsync_event |=> !hsync_event; endproperty
  a_hev: assert property (p_hev) else $error("hsync long");
  property p_vev; vsync_event |=> !vsync_event; endproperty
  a_vev: assert property (p_vev) else $error("vsync long");
  c_cw: cover property (cw);
  c_hev: cover property (hsync_event);
  c_vev: cover property (vsync_event);
endmodule
bind spc_top spc_top_checker u_chk (.clock, .rstn, .psel, .penable, .pwrite, .paddr,
  .pready, .pslverr, .sync_port_a_oe, .sync_port_b_oe, .hsync_event, .vsync_event);
`default_nettype wire

// ---- spc_far_source.sv ----
`timescale 1ns/100ps
`default_nettype none
module spc_far_source (
  // Pin controls and far-side levels
  input  wire logic a_o,
  input  wire logic a_oe,
  input  wire logic b_o,
  input  wire logic b_oe,
  input  wire logic drv_a,
  input  wire logic drv_b,
  output wire logic a_pin,
  output wire logic b_pin
);
  // Far source backs off while the encoder drives, so no contention
  assign a_pin = a_oe ? a_o : drv_a;
  assign b_pin = b_oe ? b_o : drv_b;
endmodule
`default_nettype wire

// ---- test_sync_port_config.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_sync_port_config;
  logic clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, field_start = 0;
  logic odd_field = 0, embedded_hsync = 0, drv_a = 0, drv_b = 0, pa = 0, pb = 0, er;
  logic [11:0] paddr = '0;
  logic [10:0] pixel_count = '0, line_count = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, a_o, a_oe, b_o, b_oe, a_pin, b_pin, hsync_event, vsync_event, ext_blank;
  int n_mismatch = 0, checked = 0, nv = 0, nh = 0, na = 0, nb = 0, v0;
  int bc[4] = '{32, 33, 36, 4}, bh[4] = '{1, 1, 1, 0}, bl[4] = '{0, 0, 1, 1};
  int ty[6] = '{0, 1, 2, 2, 2, 3}, st[6] = '{0, 0, 0, 1, 2, 0}, ex[6] = '{24, 12, 6, 3, 2, 0};
  int oc[4] = '{2, 3, 6, 7}, ol[4] = '{2, 50, 2, 50}, ox[4] = '{10, 10, 0, 10};
  spc_top dut (.clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pixel_count, .line_count, .field_start, .odd_field, .embedded_hsync,
    .sync_port_a_i(a_pin), .sync_port_a_o(a_o), .sync_port_a_oe(a_oe), .sync_port_b_i(b_pin),
    .sync_port_b_o(b_o), .sync_port_b_oe(b_oe), .hsync_event, .vsync_event, .ext_blank);
  spc_far_source far (.a_o, .a_oe, .b_o, .b_oe, .drv_a, .drv_b, .a_pin, .b_pin);
  initial forever #2.5 clock = ~clock;
  // Event tallies; nb counts pulse cycles, and a window of one full line holds one pulse, none in vblank with bit 2 set
  always @(posedge clock) begin
    nv <= nv + vsync_event;
    nh <= nh + hsync_event;
    na <= na + (a_oe & (a_o ^ pa));
    nb <= nb + (b_oe & (b_o ^ pb));
    pixel_count <= pixel_count == 11'h03f ? 11'h000 : pixel_count + 11'h001;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %0t %s got %0h exp %0h", $time, m, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    if (n >= 50) chk(0, 1, "apb hang");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic step(input logic a, input logic b);
    drv_a <= a;
    drv_b <= b;
    repeat (10) @(posedge clock);
  endtask
  task automatic wrap_up;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #50000;
    chk(0, 1, "watchdog");
    wrap_up;
  end
  initial begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    apb(0, 12'h1ac, 0);
    chk(rd, 0, "ctrl reset");
    chk({a_oe, b_oe}, 0, "pins in");
    apb(0, 12'h07c, 0);
    chk(er, 1, "unmapped");
    $display("reset test done");
    for (int p = 0; p < 2; p++) begin
      apb(1, 12'h1ac, 32'(p * 8));
      step(p[0], 0);
      v0 = nv;
      step(!p[0], 0);
      chk(nv - v0, 1, "a edge");
      step(p[0], 0);
      chk(nv - v0, 1, "a back");
    end
    for (int i = 0; i < 4; i++) begin
      apb(1, 12'h1ac, 32'(bc[i]));
      step(0, bc[i][0]);
      v0 = nh;
      step(0, !bc[i][0]);
      chk(nh - v0, bh[i], "b edge");
      chk(ext_blank, bl[i], "b blank");
      step(0, bc[i][0]);
    end
    apb(1, 12'h074, 32'h0000_0001);
    apb(1, 12'h1ac, 32'h0000_0000);
    v0 = nh;
    embedded_hsync <= 1'b1;
    @(posedge clock);
    embedded_hsync <= 1'b0;
    step(1, 0);
    chk(nh - v0, 1, "embedded hsync");
    apb(1, 12'h1ac, 32'h0000_0024);
    v0 = nh;
    step(1, 1);
    chk(nh - v0, 0, "embedded b");
    chk(ext_blank, 0, "embedded blank");
    apb(1, 12'h074, 32'h0000_0000);
    step(1, 1);
    chk(ext_blank, 1, "blank back");
    step(0, 0);
    $display("input test done");
    for (int i = 0; i < 6; i++) begin
      apb(1, 12'h074, 32'(st[i] * 16));
      apb(1, 12'h1ac, 32'(ty[i] * 64 + 16 + ty[i] % 2 * 8));
      pa <= ty[i][0];
      repeat (10) @(posedge clock);
      v0 = na;
      for (int f = 0; f < 24; f++) begin
        odd_field <= f[0];
        field_start <= 1'b1;
        @(posedge clock);
        field_start <= 1'b0;
        repeat (3) @(posedge clock);
      end
      repeat (5) @(posedge clock);
      chk(na - v0, ex[i], "a pulses");
    end
    apb(1, 12'h078, 32'h0014_000a);
    apb(1, 12'h070, 32'h0064_0005);
    for (int i = 0; i < 4; i++) begin
      apb(1, 12'h1ac, 32'(oc[i]));
      pb <= oc[i][0];
      line_count <= 11'(ol[i]);
      repeat (70) @(posedge clock);
      v0 = nb;
      repeat (64) @(posedge clock);
      chk(nb - v0, ox[i], "b pulse");
    end
    $display("output test done");
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    apb(0, 12'h1ac, 0);
    chk(rd, 0, "ctrl after reset");
    chk({a_oe, b_oe}, 0, "pins released");
    $display("second reset test done");
    wrap_up;
  end
endmodule
`default_nettype wire
